// [bench/clfac_far_side.sv]
// far-side model: level probes, thermocouple front end, valve and relay
// assumes the bench loads levels and injects faults between clock edges
module clfac_far_side
	import clfac_pkg::*;
#(
	parameter int unsigned FILL_CYC = 6
)(
	input wire logic clk, // system clock
	input wire logic valveOpen, // valve drive from the block
	input wire logic relayToNo, // relay normal path
	input wire logic relayToNc, // relay error path
	input wire logic levelLoad, // load levelSet
	input wire logic [2:0] levelSet, // probes submerged from the bottom
	input wire logic fillOn, // supply present behind the valve
	input wire logic probeCut, // probe assembly unplugged
	input wire logic tcCut, // thermocouple unplugged
	input wire logic signed [TEMP_W-1:0] tempSet, // vessel temperature
	output logic [3:0] probeWet, // probe submerged flags
	output logic probeOpen, // open probe circuit
	output logic tcOpen, // open thermocouple
	output logic signed [TEMP_W-1:0] tempIn, // converted temperature
	output logic contactOk // exactly one relay path closed
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] level_q = 3'h0;
	logic [3:0] fillCnt_q = 4'h0;
	logic signed [TEMP_W-1:0] noise_q = 16'h0000;

	// liquid climbs one probe per FILL_CYC cycles only while fed and open
	always_ff @(posedge clk)
	begin
		fillCnt_q <= (fillCnt_q == 4'(FILL_CYC - 1)) ? 4'h0 : fillCnt_q + 4'h1;
		if (levelLoad)
			level_q <= levelSet;
		else if (fillOn && valveOpen && fillCnt_q == 4'h0 && level_q < 3'h4)
			level_q <= level_q + 3'h1;
	end

	// an open front end reads garbage, so a stale value cannot pass
	always_ff @(posedge clk)
		noise_q <= noise_q + 16'h0125;

	// bit0 is the bottom probe, bit3 the top one
	always_comb
		for (int i = 0; i < 4; i++)
			probeWet[i] = (level_q > 3'(i));
	assign probeOpen = probeCut;
	assign tcOpen = tcCut;
	assign tempIn = tcCut ? noise_q : tempSet;
	assign contactOk = relayToNo ^ relayToNc;
endmodule

// [bench/clfac_top_test.sv]
// self-checking bench for the level, fill and alarm controller
// assumes shortened minute, sample and flash counts on the instance
module clfac_top_test
	import clfac_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MIN = 20;
	typedef struct packed
	{
		logic [2:0] lvl;
		logic [3:0] lamps;
		logic lo;
		logic hi;
	} clfac_row_t;
	clfac_row_t rows [5] = '{'{3'h0, 4'h0, 1'b1, 1'b0},
		'{3'h1, 4'h1, 1'b0, 1'b0}, '{3'h2, 4'h3, 1'b0, 1'b0},
		'{3'h3, 4'h7, 1'b0, 1'b0}, '{3'h4, 4'hF, 1'b0, 1'b1}};
	logic clk = 1'b0;
	logic sysRst = 1'b1;
	clfac_axil_req_t axiReq = '0;
	clfac_axil_rsp_t axiRsp;
	logic [3:0] probeWet, lampOn;
	logic probeValid = 1'b0;
	logic probeOpen, tcOpen, valveOpen, displayFlash, toneOn;
	logic signed [TEMP_W-1:0] tempIn, tempShown;
	logic signed [TEMP_W-1:0] tempSet = 16'hFF42;
	logic muteBtn = 1'b0;
	logic levelLoad = 1'b1;
	logic [2:0] levelSet = 3'h0;
	logic fillOn = 1'b0;
	logic probeCut = 1'b0;
	logic tcCut = 1'b0;
	clfac_alarm_t alarms;
	logic [2:0] textCode;
	logic [3:0] scrollPos;
	logic relayToNo, relayToNc, tempShownValid, contactOk, flashWas;
	int failures = 0;
	int testsRun = 0;
	int cycles = 0;
	int n;

	clfac_top #(.MINUTE_CYCLES(MIN), .SAMPLE_CYCLES(4), .FLASH_CYCLES(4),
		.SAMPLES(4)) dut (.clk(clk), .sys_rst(sysRst), .axiReq(axiReq),
		.axiRsp(axiRsp), .probeWet(probeWet), .probeValid(probeValid),
		.probeOpen(probeOpen), .tcOpen(tcOpen), .tempIn(tempIn),
		.muteBtn(muteBtn), .valveOpen(valveOpen), .lampOn(lampOn),
		.alarms(alarms), .displayFlash(displayFlash), .toneOn(toneOn),
		.textCode(textCode), .scrollPos(scrollPos), .relayToNo(relayToNo),
		.relayToNc(relayToNc), .tempShown(tempShown),
		.tempShownValid(tempShownValid));
	clfac_far_side far (.clk(clk), .valveOpen(valveOpen),
		.relayToNo(relayToNo), .relayToNc(relayToNc), .levelLoad(levelLoad),
		.levelSet(levelSet), .fillOn(fillOn), .probeCut(probeCut),
		.tcCut(tcCut), .tempSet(tempSet), .probeWet(probeWet),
		.probeOpen(probeOpen), .tcOpen(tcOpen), .tempIn(tempIn),
		.contactOk(contactOk));

	// clock and a hang limit well above the planned run length
	initial
	begin
		forever #20 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			give_verdict();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		testsRun++;
		if (got !== exp)
		begin
			failures++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// write with both halves offered at once; an edge passes after release
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] er);
		axiReq.awvalid <= 1'b1;
		axiReq.awaddr <= a;
		axiReq.wvalid <= 1'b1;
		axiReq.wdata <= d;
		axiReq.wstrb <= 4'hF;
		axiReq.bready <= 1'b1;
		for (int k = 0; k < 20; k++)
		begin
			@(posedge clk);
			if (axiRsp.awready)
				axiReq.awvalid <= 1'b0;
			if (axiRsp.wready)
				axiReq.wvalid <= 1'b0;
			if (axiRsp.bvalid === 1'b1)
				break;
		end
		axiReq.bready <= 1'b0;
		chk(32'(axiRsp.bresp), 32'(er));
		@(posedge clk);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		axiReq.arvalid <= 1'b1;
		axiReq.araddr <= a;
		axiReq.rready <= 1'b1;
		for (int k = 0; k < 20; k++)
		begin
			@(posedge clk);
			if (axiRsp.arready)
				axiReq.arvalid <= 1'b0;
			if (axiRsp.rvalid === 1'b1)
				break;
		end
		axiReq.rready <= 1'b0;
		chk(axiRsp.rdata, ed);
		chk(32'(axiRsp.rresp), 32'(er));
		@(posedge clk);
	endtask

	task automatic setLevel(input logic [2:0] l);
		levelLoad <= 1'b1;
		levelSet <= l;
		@(posedge clk);
		levelLoad <= 1'b0;
	endtask

	task give_verdict;
		$display("checks %0d mismatches %0d", testsRun, failures);
		if (failures == 0 && testsRun > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// main sequence: quiet start, registers, table, then awkward cases
	initial
	begin
		repeat (3) @(posedge clk);
		sysRst <= 1'b0;
		levelLoad <= 1'b0;
		repeat (5) @(posedge clk);
		chk(32'(valveOpen), 32'h0);
		chk(32'(alarms), 32'h0);
		chk(32'(relayToNo), 32'h1);
		rd(ADDR_CTRL, 32'(RST_TCEN), RESP_OKAY);
		rd(ADDR_LIMITS, 32'(FILL_MIN_LO), RESP_OKAY);
		rd(ADDR_STEPS, 32'({RST_REMOTE, RST_RETRIG}), RESP_OKAY);
		rd(ADDR_THRESH, 32'(RST_THRESH), RESP_OKAY);
		rd(12'h018, 32'h0000_0000, RESP_SLVERR);
		wr(12'h020, 32'h0000_0001, RESP_SLVERR);
		wr(ADDR_LIMITS, 32'h0000_0005, RESP_OKAY);
		rd(ADDR_LIMITS, 32'(FILL_MIN_LO), RESP_OKAY);
		wr(ADDR_LIMITS, 32'h0000_FFC8, RESP_OKAY);
		rd(ADDR_LIMITS, 32'({TDLY_MAX, FILL_MIN_HI}), RESP_OKAY);
		wr(ADDR_STEPS, 32'h0000_6464, RESP_OKAY);
		rd(ADDR_STEPS, 32'({STEPS_MAX, STEPS_MAX}), RESP_OKAY);
		wr(ADDR_STEPS, 32'h0000_0101, RESP_OKAY);
		wr(ADDR_LIMITS, 32'h0000_021E, RESP_OKAY);
		$display("test registers done");
		probeValid <= 1'b1;
		for (int i = 0; i < 5; i++)
		begin
			setLevel(rows[i].lvl);
			repeat (3) @(posedge clk);
			chk(32'(lampOn), 32'(rows[i].lamps));
			chk(32'(alarms.lowLevel), 32'(rows[i].lo));
			chk(32'(alarms.highLevel), 32'(rows[i].hi));
		end
		$display("test level table done");
		setLevel(3'h3);
		fillOn <= 1'b1;
		// let an edge pass so the load strobe is not driven twice at once
		@(posedge clk);
		setLevel(3'h1);
		repeat (3) @(posedge clk);
		chk(32'(valveOpen), 32'h1);
		for (n = 0; n < 20 && probeWet[1] !== 1'b1; n++) @(posedge clk);
		repeat (2) @(posedge clk);
		chk(32'(valveOpen), 32'h1);
		for (n = 0; n < 20 && probeWet[2] !== 1'b1; n++) @(posedge clk);
		repeat (3) @(posedge clk);
		chk(32'(valveOpen), 32'h0);
		fillOn <= 1'b0;
		setLevel(3'h2);
		repeat (3) @(posedge clk);
		chk(32'(valveOpen), 32'h0);
		$display("test fill cycle done");
		setLevel(3'h1);
		repeat (570) @(posedge clk);
		chk(32'(alarms.fillTimeout), 32'h0);
		for (n = 0; n < 80 && alarms.fillTimeout !== 1'b1; n++) @(posedge clk);
		repeat (2) @(posedge clk);
		chk(32'(alarms.fillTimeout), 32'h1);
		chk(32'(textCode), 32'h6);
		setLevel(3'h3);
		repeat (3) @(posedge clk);
		chk(32'(alarms.fillTimeout), 32'h0);
		$display("test fill timeout done");
		setLevel(3'h0);
		repeat (170) @(posedge clk);
		chk(32'(relayToNo), 32'h1);
		chk(32'(toneOn), 32'h1);
		chk(32'(textCode), 32'h1);
		chk(32'(scrollPos != 4'h0), 32'h1);
		for (n = 0; n < 60 && relayToNo !== 1'b0; n++) @(posedge clk);
		chk(32'({relayToNo, relayToNc, contactOk}), 32'h3);
		muteBtn <= 1'b1;
		@(posedge clk);
		muteBtn <= 1'b0;
		repeat (3) @(posedge clk);
		flashWas = displayFlash;
		chk(32'({toneOn, relayToNc}), 32'h1);
		repeat (4) @(posedge clk);
		chk(32'(displayFlash), 32'(!flashWas));
		repeat (160) @(posedge clk);
		chk(32'(toneOn), 32'h0);
		for (n = 0; n < 60 && toneOn !== 1'b1; n++) @(posedge clk);
		chk(32'(toneOn), 32'h1);
		setLevel(3'h3);
		repeat (4) @(posedge clk);
		chk(32'({relayToNo, relayToNc}), 32'h2);
		$display("test relay and tone done");
		tempSet <= 16'hFFCE;
		for (n = 0; n < 40 && !(tempShown > $signed(RST_THRESH)); n++)
			@(posedge clk);
		repeat (10) @(posedge clk);
		chk(32'(alarms.hiTemp), 32'h0);
		for (n = 0; n < 40 && tempShown !== 16'hFFCE; n++) @(posedge clk);
		chk(32'({tempShownValid, tempShown}), 32'h1_FFCE);
		rd(ADDR_TEMP, 32'h0001_FFCE, RESP_OKAY);
		for (n = 0; n < 60 && alarms.hiTemp !== 1'b1; n++) @(posedge clk);
		chk(32'(alarms.hiTemp), 32'h1);
		tcCut <= 1'b1;
		repeat (3) @(posedge clk);
		chk(32'(alarms.tcOpen), 32'h1);
		wr(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
		repeat (3) @(posedge clk);
		chk(32'({alarms.hiTemp, alarms.tcOpen}), 32'h0);
		chk(32'({tempShownValid, tempShown}), 32'h0);
		probeCut <= 1'b1;
		repeat (4) @(posedge clk);
		chk(32'(alarms.sensorFault), 32'h1);
		chk(32'(textCode), 32'h3);
		// mute through the control word: tone stops, the rest stays
		wr(ADDR_CTRL, 32'h0000_0002, RESP_OKAY);
		repeat (2) @(posedge clk);
		chk(32'(toneOn), 32'h0);
		// sensor fault, muted, armed, lamps 0 to 2 lit, valve shut
		rd(ADDR_STATUS, 32'h0000_0927, RESP_OKAY);
		$display("test temperature and faults done");
		give_verdict();
	end
endmodule

// [common/clfac_pkg.sv]
// constants, bus carriers and alarm set for the cryogenic level, fill and
// alarm controller; assumes a single 25 MHz clock and an AXI4-Lite master
package clfac_pkg;

	// timing: clock rate and the real-time units derived from it
	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int unsigned MINUTE_S = 60;
	localparam int unsigned MINUTE_CYC = CLK_HZ * MINUTE_S;
	localparam int unsigned SAMPLE_MS = 250;
	localparam int unsigned SAMPLE_CYC = CLK_HZ / 1000 * SAMPLE_MS;
	localparam int unsigned FLASH_MS = 500;
	localparam int unsigned FLASH_CYC = CLK_HZ / 1000 * FLASH_MS;
	localparam int unsigned STEP_MIN = 10;

	// temperature averaging: four samples a second, mean by shift
	localparam int unsigned TEMP_W = 16;
	localparam int unsigned AVG_SHIFT = 2;

	// register byte addresses
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_LIMITS = 12'h004;
	localparam logic [11:0] ADDR_STEPS = 12'h008;
	localparam logic [11:0] ADDR_THRESH = 12'h00C;
	localparam logic [11:0] ADDR_STATUS = 12'h010;
	localparam logic [11:0] ADDR_TEMP = 12'h014;

	// field positions
	localparam int unsigned CTRL_TCEN = 0;
	localparam int unsigned CTRL_MUTE = 1;
	localparam int unsigned ST_VALVE = 4;
	localparam int unsigned ST_READY = 5;
	localparam int unsigned ST_TONE = 6;
	localparam int unsigned ST_RELAY = 7;
	localparam int unsigned ST_MUTED = 8;
	localparam int unsigned ST_ALARM = 9;
	localparam int unsigned TEMP_VALID = 16;

	// reset values and programmable ranges
	localparam logic RST_TCEN = 1'b1;
	localparam logic [7:0] FILL_MIN_LO = 8'h1E;
	localparam logic [7:0] FILL_MIN_HI = 8'h78;
	localparam logic [7:0] TDLY_MAX = 8'h3C;
	localparam logic [7:0] RST_TDLY = 8'h00;
	localparam logic [7:0] STEPS_MAX = 8'h48;
	localparam logic [7:0] RST_RETRIG = 8'h01;
	localparam logic [7:0] RST_REMOTE = 8'h03;
	localparam logic [15:0] RST_THRESH = 16'hFF9C;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef struct packed {
		logic awvalid;
		logic [11:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [11:0] araddr;
		logic rready;
	} clfac_axil_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} clfac_axil_rsp_t;

	typedef struct packed {
		logic fillTimeout;
		logic tcOpen;
		logic hiTemp;
		logic sensorFault;
		logic highLevel;
		logic lowLevel;
	} clfac_alarm_t;

	typedef enum logic {FILL_IDLE, FILL_RUN} clfac_fill_t;

endpackage

// [rtl/clfac_delay.sv]
// minute-based persistence timer: counts minute ticks while run is high
// assumes tick is a one-cycle pulse once a minute
module clfac_delay
	import clfac_pkg::*;
#(
	parameter int unsigned W = 10
)(
	input wire logic clk, // system clock
	input wire logic sys_rst, // synchronous reset, high
	input wire logic run, // condition being timed
	input wire logic tick, // one pulse per minute
	input wire logic [W-1:0] limit, // minutes to persist
	output logic expired // run has held for limit minutes
);
	logic [W-1:0] cnt_q;

	// restart whenever the condition drops; saturate so a held
	// condition keeps expired high without wrapping
	always_ff @(posedge clk)
	begin
		if (sys_rst || !run)
			cnt_q <= '0;
		else if (tick && cnt_q < limit)
			cnt_q <= cnt_q + 1'b1;
	end

	assign expired = run && (cnt_q >= limit);
endmodule

// [rtl/clfac_top.sv]
// level control, fill valve, alarm timing and register slave
// assumes probe, temperature and button inputs are synchronous to clk
module clfac_top
	import clfac_pkg::*;
#(
	parameter int unsigned MINUTE_CYCLES = MINUTE_CYC,
	parameter int unsigned SAMPLE_CYCLES = SAMPLE_CYC,
	parameter int unsigned FLASH_CYCLES = FLASH_CYC,
	parameter int unsigned SAMPLES = 4
)(
	input wire logic clk, // 25 MHz system clock
	input wire logic sys_rst, // synchronous reset, high
	input wire clfac_axil_req_t axiReq, // AXI4-Lite master side
	output clfac_axil_rsp_t axiRsp, // AXI4-Lite slave side
	input wire logic [3:0] probeWet, // probe submerged, bit0 lowest
	input wire logic probeValid, // probe readings settled
	input wire logic probeOpen, // probe assembly open circuit
	input wire logic tcOpen, // thermocouple open circuit
	input wire logic signed [TEMP_W-1:0] tempIn, // temperature, deg C
	input wire logic muteBtn, // mute button pulse
	output logic valveOpen, // fill valve drive
	output logic [3:0] lampOn, // level lamps
	output clfac_alarm_t alarms, // active alarms
	output logic displayFlash, // display flash phase
	output logic toneOn, // alarm tone
	output logic [2:0] textCode, // error text shown, 0 none
	output logic [3:0] scrollPos, // text scroll step
	output logic relayToNo, // common joined to normal contact
	output logic relayToNc, // common joined to error contact
	output logic signed [TEMP_W-1:0] tempShown, // displayed temperature
	output logic tempShownValid // temperature display on
);
	logic ready_q, tcEn_q, muted_q, toneOn_q, relay_q, flash_q;
	logic [7:0] fillMin_q, tDly_q, retrig_q, remote_q;
	logic signed [15:0] thresh_q;
	logic [3:0] lamp_q, scroll_q;
	logic [2:0] text_q;
	clfac_alarm_t alarm_q, alarmRaw;
	clfac_fill_t state_q;
	logic anyErr;
	logic [30:0] minCnt_q;
	logic [22:0] sampCnt_q;
	logic [23:0] flashCnt_q;
	logic minTick, sampTick, flashTick;
	logic signed [17:0] acc_q, sampSum;
	logic [1:0] nSamp_q;
	logic signed [TEMP_W-1:0] avg_q, shown_q;
	logic avgValid_q, shownValid_q;
	logic hiRaw, hiExp, fillExp, retrigExp, remoteExp;
	logic [9:0] retrigMin, remoteMin;
	logic awHeld_q, wHeld_q, bValid_q, rValid_q;
	logic [11:0] awAddr_q;
	logic [31:0] wData_q, rData_q, wrWord, rdWord, wrMerged;
	logic [3:0] wStrb_q;
	logic [1:0] bResp_q, rResp_q;
	logic doWrite, wrHit, rdHit, arTake, muteWr;

	// byte-lane merge so partial writes keep untouched lanes
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[8*i +: 8] = nw[8*i +: 8];
		return r;
	endfunction

	function automatic logic [7:0] clamp(input logic [7:0] v,
		input logic [7:0] lo, input logic [7:0] hi);
		return (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	// register readback for a given address; hit flags mapped ones
	function automatic logic [32:0] regWord(input logic [11:0] a);
		logic [31:0] st;
		st = {17'h0_0000, alarm_q, muted_q, relay_q, toneOn_q, ready_q,
			valveOpen, lamp_q};
		case (a)
			ADDR_CTRL: return {1'b1, 31'h0, tcEn_q};
			ADDR_LIMITS: return {1'b1, 16'h0000, tDly_q, fillMin_q};
			ADDR_STEPS: return {1'b1, 16'h0000, remote_q, retrig_q};
			ADDR_THRESH: return {1'b1, 16'h0000, thresh_q};
			ADDR_STATUS: return {1'b1, st};
			ADDR_TEMP: return {1'b1, 15'h0000, avgValid_q, avg_q};
			default: return 33'h0_0000_0000;
		endcase
	endfunction

	// bus channels: address and data are taken in either order
	assign axiRsp.awready = !awHeld_q && !bValid_q;
	assign axiRsp.wready = !wHeld_q && !bValid_q;
	assign axiRsp.bvalid = bValid_q;
	assign axiRsp.bresp = bResp_q;
	assign axiRsp.arready = !rValid_q;
	assign axiRsp.rvalid = rValid_q;
	assign axiRsp.rdata = rData_q;
	assign axiRsp.rresp = rResp_q;
	assign doWrite = awHeld_q && wHeld_q;
	assign arTake = axiReq.arvalid && !rValid_q;
	// readback in a process: a continuous assign would only re-run on an
	// address change and hand out stale words after a register update
	always_comb
	begin
		{wrHit, wrWord} = regWord(awAddr_q);
		{rdHit, rdWord} = regWord(axiReq.araddr);
		wrMerged = merge(wrWord, wData_q, wStrb_q);
	end
	assign muteWr = doWrite && awAddr_q == ADDR_CTRL && wStrb_q[0]
		&& wData_q[CTRL_MUTE];

	// write path: hold each half, then commit and answer together
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
			bValid_q <= 1'b0;
			bResp_q <= RESP_OKAY;
			awAddr_q <= 12'h000;
			wData_q <= 32'h0000_0000;
			wStrb_q <= 4'h0;
		end
		else
		begin
			if (axiReq.awvalid && axiRsp.awready)
			begin
				awHeld_q <= 1'b1;
				awAddr_q <= axiReq.awaddr;
			end
			if (axiReq.wvalid && axiRsp.wready)
			begin
				wHeld_q <= 1'b1;
				wData_q <= axiReq.wdata;
				wStrb_q <= axiReq.wstrb;
			end
			if (doWrite)
			begin
				awHeld_q <= 1'b0;
				wHeld_q <= 1'b0;
				bValid_q <= 1'b1;
				bResp_q <= wrHit ? RESP_OKAY : RESP_SLVERR;
			end
			else if (bValid_q && axiReq.bready)
				bValid_q <= 1'b0;
		end
	end

	// read path: one cycle from address to data
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			rValid_q <= 1'b0;
			rData_q <= 32'h0000_0000;
			rResp_q <= RESP_OKAY;
		end
		else if (arTake)
		begin
			rValid_q <= 1'b1;
			rData_q <= rdWord;
			rResp_q <= rdHit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (rValid_q && axiReq.rready)
			rValid_q <= 1'b0;
	end

	// settings; out-of-range writes are clamped rather than refused
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			tcEn_q <= RST_TCEN;
			fillMin_q <= FILL_MIN_LO;
			tDly_q <= RST_TDLY;
			retrig_q <= RST_RETRIG;
			remote_q <= RST_REMOTE;
			thresh_q <= RST_THRESH;
		end
		else if (doWrite)
		begin
			case (awAddr_q)
				ADDR_CTRL: tcEn_q <= wrMerged[CTRL_TCEN];
				ADDR_LIMITS:
				begin
					fillMin_q <= clamp(wrMerged[7:0],
						FILL_MIN_LO, FILL_MIN_HI);
					tDly_q <= clamp(wrMerged[15:8],
						8'h00, TDLY_MAX);
				end
				ADDR_STEPS:
				begin
					retrig_q <= clamp(wrMerged[7:0],
						8'h00, STEPS_MAX);
					remote_q <= clamp(wrMerged[15:8],
						8'h00, STEPS_MAX);
				end
				ADDR_THRESH: thresh_q <= wrMerged[15:0];
				default: ;
			endcase
		end
	end

	// time bases: minute, sample and flash ticks
	assign minTick = minCnt_q == 31'(MINUTE_CYCLES - 1);
	assign sampTick = sampCnt_q == 23'(SAMPLE_CYCLES - 1);
	assign flashTick = flashCnt_q == 24'(FLASH_CYCLES - 1);
	always_ff @(posedge clk)
	begin
		if (sys_rst || minTick)
			minCnt_q <= '0;
		else
			minCnt_q <= minCnt_q + 1'b1;
	end
	always_ff @(posedge clk)
	begin
		if (sys_rst || sampTick)
			sampCnt_q <= '0;
		else
			sampCnt_q <= sampCnt_q + 1'b1;
	end
	always_ff @(posedge clk)
	begin
		if (sys_rst || flashTick)
			flashCnt_q <= '0;
		else
			flashCnt_q <= flashCnt_q + 1'b1;
	end

	// temperature mean over one second of samples
	assign sampSum = acc_q + 18'(tempIn);
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			acc_q <= '0;
			nSamp_q <= 2'h0;
			avg_q <= '0;
			avgValid_q <= 1'b0;
		end
		else if (sampTick)
		begin
			if (nSamp_q == 2'(SAMPLES - 1))
			begin
				avg_q <= TEMP_W'(sampSum >>> AVG_SHIFT);
				avgValid_q <= 1'b1;
				acc_q <= '0;
				nSamp_q <= 2'h0;
			end
			else
			begin
				acc_q <= sampSum;
				nSamp_q <= nSamp_q + 1'b1;
			end
		end
	end

	// displayed temperature is blanked with the sensor off
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			shown_q <= '0;
			shownValid_q <= 1'b0;
		end
		else
		begin
			shown_q <= (tcEn_q && avgValid_q) ? avg_q : '0;
			shownValid_q <= tcEn_q && avgValid_q;
		end
	end

	// nothing acts on the probes until a first valid reading
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			ready_q <= 1'b0;
		else if (probeValid)
			ready_q <= 1'b1;
	end

	// fill cycle: begin probe dry starts, end probe wet stops
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			state_q <= FILL_IDLE;
		else
		begin
			case (state_q)
				FILL_IDLE: if (ready_q && !probeWet[1])
					state_q <= FILL_RUN;
				FILL_RUN: if (probeWet[2])
					state_q <= FILL_IDLE;
				default: state_q <= FILL_IDLE;
			endcase
		end
	end
	assign valveOpen = state_q == FILL_RUN;

	// lamps mirror the probes once readings are valid
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			lamp_q <= 4'h0;
		else
			lamp_q <= ready_q ? probeWet : 4'h0;
	end

	// persistence timers in minutes
	assign hiRaw = ready_q && tcEn_q && avgValid_q && avg_q > thresh_q;
	assign retrigMin = 10'(retrig_q) * 10'(STEP_MIN);
	assign remoteMin = 10'(remote_q) * 10'(STEP_MIN);
	clfac_delay #(.W(10)) uHiDly (.clk(clk), .sys_rst(sys_rst),
		.run(hiRaw), .tick(minTick), .limit(10'(tDly_q)),
		.expired(hiExp));
	clfac_delay #(.W(10)) uFillDly (.clk(clk), .sys_rst(sys_rst),
		.run(valveOpen), .tick(minTick), .limit(10'(fillMin_q)),
		.expired(fillExp));
	clfac_delay #(.W(10)) uRetrig (.clk(clk), .sys_rst(sys_rst),
		.run(muted_q && anyErr), .tick(minTick), .limit(retrigMin),
		.expired(retrigExp));
	clfac_delay #(.W(10)) uRemote (.clk(clk), .sys_rst(sys_rst),
		.run(anyErr), .tick(minTick), .limit(remoteMin),
		.expired(remoteExp));

	// raw alarm conditions, all held off before the first reading
	always_comb
	begin
		alarmRaw.lowLevel = ready_q && !probeWet[0];
		alarmRaw.highLevel = ready_q && probeWet[3];
		alarmRaw.sensorFault = ready_q && probeOpen;
		alarmRaw.hiTemp = hiExp;
		alarmRaw.tcOpen = ready_q && tcEn_q && tcOpen;
		alarmRaw.fillTimeout = fillExp;
	end
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			alarm_q <= '0;
		else
			alarm_q <= alarmRaw;
	end
	assign anyErr = |alarm_q;

	// mute: a new press wins over the re-trigger clear
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			muted_q <= 1'b0;
		else if ((muteBtn || muteWr) && anyErr)
			muted_q <= 1'b1;
		else if (retrigExp || !anyErr)
			muted_q <= 1'b0;
	end

	// annunciators: tone, relay, flash, text and scroll
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			toneOn_q <= 1'b0;
			relay_q <= 1'b0;
		end
		else
		begin
			toneOn_q <= anyErr && !muted_q;
			relay_q <= remoteExp;
		end
	end
	always_ff @(posedge clk)
	begin
		if (sys_rst || !anyErr)
		begin
			flash_q <= 1'b0;
			scroll_q <= 4'h0;
		end
		else if (flashTick)
		begin
			flash_q <= !flash_q;
			scroll_q <= scroll_q + 1'b1;
		end
	end
	// lowest-numbered active alarm names the text shown
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			text_q <= 3'h0;
		else if (alarm_q.lowLevel)
			text_q <= 3'h1;
		else if (alarm_q.highLevel)
			text_q <= 3'h2;
		else if (alarm_q.sensorFault)
			text_q <= 3'h3;
		else if (alarm_q.hiTemp)
			text_q <= 3'h4;
		else if (alarm_q.tcOpen)
			text_q <= 3'h5;
		else if (alarm_q.fillTimeout)
			text_q <= 3'h6;
		else
			text_q <= 3'h0;
	end

	assign lampOn = lamp_q;
	assign alarms = alarm_q;
	assign displayFlash = flash_q;
	assign toneOn = toneOn_q;
	assign textCode = text_q;
	assign scrollPos = scroll_q;
	assign relayToNo = !relay_q;
	assign relayToNc = relay_q;
	assign tempShown = shown_q;
	assign tempShownValid = shownValid_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence fillStart;
		ready_q && state_q == FILL_IDLE && !probeWet[1];
	endsequence
	sequence fillEnd;
		valveOpen && probeWet[2];
	endsequence

	a_valve_opens: assert property (fillStart |=> valveOpen)
		else $error("valve did not open");
	a_valve_closes: assert property (fillEnd |=> !valveOpen)
		else $error("valve did not close");
	a_lamp_follows: assert property (ready_q |=> lampOn == $past(probeWet))
		else $error("lamp does not follow probe");
	a_low_level: assert property (
		ready_q && !probeWet[0] |=> alarms.lowLevel)
		else $error("low level alarm missing");
	a_high_level: assert property (
		ready_q && probeWet[3] |=> alarms.highLevel)
		else $error("high level alarm missing");
	a_sensor_fault: assert property (
		ready_q && probeOpen |=> alarms.sensorFault)
		else $error("sensor fault alarm missing");
	a_quiet_start: assert property (
		!ready_q |-> !valveOpen && alarms == '0 && !toneOn)
		else $error("activity before valid probes");
	a_relay_contacts: assert property (relayToNo != relayToNc)
		else $error("relay contacts inconsistent");
	a_relay_rest: assert property (!anyErr |=> relayToNo)
		else $error("relay off normal contact without error");
	a_mute_tone: assert property (muted_q |=> !toneOn)
		else $error("tone sounds while muted");
	a_sensor_off: assert property (
		!tcEn_q ##1 !tcEn_q |=> !alarms.hiTemp && !tempShownValid)
		else $error("temperature active with sensor off");
	a_tone_on_error: assert property (
		anyErr && !muted_q |=> toneOn)
		else $error("tone missing on error");
endmodule
